// ===== core/rtcp_rtc.sv
// Real-time counter core with register port, flags, events and read sync.
//
// Implementation choices: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
`include "rtcp_map.svh"
module rtcp_rtc #(
    parameter int CNT_W = `RTCP_CNT_W,
    parameter int PRESC_W = `RTCP_PRESC_W,
    parameter int SYNC_CYC = `RTCP_SYNC_BUS_CYC
) (
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic i_counter_generic_clock,
    input wire logic [7:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    output logic o_irq,
    output logic o_wake,
    output logic [PRESC_W-1:0] o_evt_periodic,
    output logic o_evt_compare,
    output logic o_evt_overflow
);
    localparam int PSEL_W = `RTCP_PSEL_W;
    localparam int FLAG_W = `RTCP_FLAG_W;
    localparam int EV_W = PRESC_W + 2;

    // ------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------
    // Control fields, written together as one word.
    logic ctrl_en;
    logic ctrl_clrmatch;
    logic ctrl_continuous_read_sync;
    logic [PSEL_W-1:0] ctrl_psel;
    // Counter, compare value, read copy and the held count write.
    logic [CNT_W-1:0] count;
    logic [CNT_W-1:0] compare;
    logic [CNT_W-1:0] count_rd;
    logic [CNT_W-1:0] snap;
    logic [CNT_W-1:0] pend_val;
    logic pend;
    // Sticky flags and the three sets of enables.
    logic [FLAG_W-1:0] flags;
    logic [FLAG_W-1:0] int_en;
    logic [FLAG_W-1:0] wake_en;
    logic [EV_W-1:0] ev_en;
    // Read sync progress.
    logic [7:0] xfer_cnt;
    rtcp_pkg::rtcp_sync_st_t sync_st;

    // ------------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------------
    // Write strobes, one per writable register.
    logic wr_ctrl;
    logic wr_count;
    logic wr_cmp;
    logic wr_clr;
    logic wr_inten;
    logic wr_even;
    logic wr_wake;
    logic wr_rreq;
    // Read sync progress and the held write.
    logic sync_busy;
    logic sync_done;
    logic apply_wr;
    logic [CNT_W-1:0] apply_val;
    // Counter-side hits and the next count.
    logic match;
    logic at_max;
    logic cmp_hit;
    logic ovf_hit;
    logic per_hit;
    logic [FLAG_W-1:0] flag_set;
    logic [CNT_W-1:0] next_count;

    // True when a write strobe targets the given offset.
    function automatic logic hit(input logic [7:0] ofs);
        return i_wr && (i_addr == ofs);
    endfunction : hit

    // A read sync request is only taken when bit 0 of the word is set.
    assign wr_ctrl = hit(`RTCP_OFS_CTRL);
    assign wr_count = hit(`RTCP_OFS_COUNT);
    assign wr_cmp = hit(`RTCP_OFS_COMPARE);
    assign wr_clr = hit(`RTCP_OFS_INTCLR);
    assign wr_inten = hit(`RTCP_OFS_INTEN);
    assign wr_even = hit(`RTCP_OFS_EVEN);
    assign wr_wake = hit(`RTCP_OFS_WAKEEN);
    assign wr_rreq = hit(`RTCP_OFS_READ_SYNC_REQUEST) && i_wdata[0];

    // ------------------------------------------------------------------
    // Prescaler
    // ------------------------------------------------------------------
    // The prescaler runs on the bus clock with enables, so no clock crosses;
    // the generic clock must therefore stay well slower than the bus clock.
    rtcp_tick_if #(.PRESC_W(PRESC_W), .PSEL_W(PSEL_W)) tk ();

    assign tk.gen_clk = i_counter_generic_clock;
    assign tk.en = ctrl_en;
    assign tk.psel = ctrl_psel;

    rtcp_prescaler #(.PRESC_W(PRESC_W), .PSEL_W(PSEL_W)) u_presc (
        .i_clk(i_clk),
        .i_rst_b(i_rst_b),
        .tk(tk)
    );

    // ------------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------------

    // Control word: enable, clear-on-match, continuous sync, ratio select.
    // Fields take effect in the cycle after the write.
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            ctrl_en <= 1'(`RTCP_CTRL_RST >> `RTCP_CTRL_EN);
            ctrl_clrmatch <= 1'b0;
            ctrl_continuous_read_sync <= 1'b0;
            ctrl_psel <= '0;
        end else if (wr_ctrl) begin
            ctrl_en <= i_wdata[`RTCP_CTRL_EN];
            ctrl_clrmatch <= i_wdata[`RTCP_CTRL_CLRMATCH];
            ctrl_continuous_read_sync <= i_wdata[`RTCP_CTRL_CONT_READ_SYNC];
            ctrl_psel <= i_wdata[`RTCP_CTRL_PSEL_LO +: PSEL_W];
        end
    end

    // Compare value; resets to all ones so a fresh counter does not match.
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            compare <= CNT_W'(`RTCP_COMPARE_RST);
        end else if (wr_cmp) begin
            compare <= i_wdata[CNT_W-1:0];
        end
    end

    // Interrupt, event and wake enables.
    // A flag that is already set raises the outputs one cycle after its
    // enable is written, so a late irq or wake enable never loses an event.
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            int_en <= '0;
            ev_en <= '0;
            wake_en <= '0;
        end else begin
            if (wr_inten) begin
                int_en <= i_wdata[FLAG_W-1:0];
            end
            if (wr_even) begin
                ev_en <= i_wdata[EV_W-1:0];
            end
            if (wr_wake) begin
                wake_en <= i_wdata[FLAG_W-1:0];
            end
        end
    end

    // ------------------------------------------------------------------
    // Read synchroniser and stalled count write
    // ------------------------------------------------------------------
    assign sync_busy = (sync_st != rtcp_pkg::SYNC_IDLE);
    assign sync_done = (sync_st == rtcp_pkg::SYNC_XFER) &&
                       (xfer_cnt == 8'(SYNC_CYC - 1));

    // With continuous sync on the sync never rests, so every count write
    // waits, up to one counter clock plus SYNC_CYC + 1 bus cycles.
    // A count write lands at once when no sync is in flight; otherwise it
    // is held and lands in the cycle the sync completes, so the bus never
    // waits but the counter keeps a coherent value.
    assign apply_wr = (wr_count && !sync_busy) || (pend && sync_done);
    assign apply_val = (wr_count && !sync_busy) ? i_wdata[CNT_W-1:0]
                                                : pend_val;

    // Sync walks: wait for a counter-side edge, snapshot, then cross over
    // a fixed number of bus cycles before the read copy updates.
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            sync_st <= rtcp_pkg::SYNC_IDLE;
            xfer_cnt <= 8'h00;
            snap <= '0;
        end else begin
            unique case (sync_st)
                rtcp_pkg::SYNC_IDLE: begin
                    if (ctrl_continuous_read_sync || wr_rreq) begin
                        sync_st <= rtcp_pkg::SYNC_CAPT;
                    end
                end
                rtcp_pkg::SYNC_CAPT: begin
                    if (tk.edge_p || !ctrl_en) begin
                        snap <= count;
                        xfer_cnt <= 8'h00;
                        sync_st <= rtcp_pkg::SYNC_XFER;
                    end
                end
                rtcp_pkg::SYNC_XFER: begin
                    xfer_cnt <= xfer_cnt + 8'h01;
                    if (sync_done) begin
                        sync_st <= ctrl_continuous_read_sync
                                   ? rtcp_pkg::SYNC_CAPT
                                   : rtcp_pkg::SYNC_IDLE;
                    end
                end
                // The unused state code falls back to idle.
                default: begin
                    sync_st <= rtcp_pkg::SYNC_IDLE;
                end
            endcase
        end
    end

    // Held write; a second write while held replaces the value.
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            pend <= 1'b0;
            pend_val <= '0;
        end else if (wr_count && sync_busy) begin
            pend <= 1'b1;
            pend_val <= i_wdata[CNT_W-1:0];
        end else if (sync_done) begin
            pend <= 1'b0;
        end
    end

    // Bus-side copy of the counter that reads of the count return.
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            count_rd <= '0;
        end else if (apply_wr) begin
            count_rd <= apply_val;
        end else if (sync_done) begin
            count_rd <= snap;
        end
    end

    // ------------------------------------------------------------------
    // Counter
    // ------------------------------------------------------------------
    // Compare and overflow count only on ticks, periodic events only on generic clock edges, so a bus write alone never raises one.
    assign match = (count == compare);
    assign at_max = (count == {CNT_W{1'b1}});
    assign cmp_hit = tk.tick && match;
    assign ovf_hit = tk.tick && at_max && !(match && ctrl_clrmatch);
    assign per_hit = |(tk.tap & ev_en[PRESC_W-1:0]);

    // Clear-on-match takes priority over the plain increment.
    always_comb begin
        if (cmp_hit && ctrl_clrmatch) begin
            next_count = '0;
        end else begin
            next_count = count + 1'b1;
        end
    end

    // A landing bus write wins over a tick in the same cycle.
    // That tick is lost; software that needs exact time writes the count
    // while the counter is disabled.
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            count <= '0;
        end else if (apply_wr) begin
            count <= apply_val;
        end else if (tk.tick) begin
            count <= next_count;
        end
    end

    // ------------------------------------------------------------------
    // Flags, interrupt and wake
    // ------------------------------------------------------------------
    // One set pulse per source; the periodic source is any enabled tap.
    always_comb begin
        flag_set = '0;
        flag_set[`RTCP_FLAG_CMP] = cmp_hit;
        flag_set[`RTCP_FLAG_OVF] = ovf_hit;
        flag_set[`RTCP_FLAG_PER] = per_hit;
    end

    // Sticky flags: a new event in the clearing cycle stays set.
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            flags <= '0;
        end else begin
            flags <= (flags & ~(wr_clr ? i_wdata[FLAG_W-1:0] : '0))
                     | flag_set;
        end
    end

    // Wake has its own enables so sleep sources can differ from irqs.
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_irq <= 1'b0;
            o_wake <= 1'b0;
        end else begin
            o_irq <= |(flags & int_en);
            o_wake <= |(flags & wake_en);
        end
    end

    // ------------------------------------------------------------------
    // Event pulses
    // ------------------------------------------------------------------

    // One-cycle event pulses, registered to keep the outputs glitch free.
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_evt_periodic <= '0;
            o_evt_compare <= 1'b0;
            o_evt_overflow <= 1'b0;
        end else begin
            o_evt_periodic <= tk.tap & ev_en[PRESC_W-1:0];
            o_evt_compare <= cmp_hit && ev_en[`RTCP_EVEN_CMP];
            o_evt_overflow <= ovf_hit && ev_en[`RTCP_EVEN_OVF];
        end
    end

    // ------------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------------

    // Reads of the count return the synced copy, never the live counter,
    // so a read may lag the counter by one sync period.
    // Read data stand for exactly the cycle after the strobe; unmapped
    // and write-only offsets read as zero.
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_rdata <= 32'h0000_0000;
        end else if (i_rd) begin
            unique case (i_addr)
                `RTCP_OFS_CTRL: begin
                    o_rdata <= 32'({ctrl_psel, 5'h00,
                                    ctrl_continuous_read_sync,
                                    ctrl_clrmatch, ctrl_en});
                end
                `RTCP_OFS_COUNT: o_rdata <= 32'(count_rd);
                `RTCP_OFS_COMPARE: o_rdata <= 32'(compare);
                `RTCP_OFS_STATUS: o_rdata <= 32'(flags);
                `RTCP_OFS_INTEN: o_rdata <= 32'(int_en);
                `RTCP_OFS_EVEN: o_rdata <= 32'(ev_en);
                `RTCP_OFS_WAKEEN: o_rdata <= 32'(wake_en);
                `RTCP_OFS_SYNC: o_rdata <= 32'({pend, sync_busy});
                default: o_rdata <= 32'h0000_0000;
            endcase
        end else begin
            o_rdata <= 32'h0000_0000;
        end
    end
endmodule : rtcp_rtc

// ===== core/rtcp_map.svh
// Offsets, field positions, reset values and timing counts of the counter.
`ifndef RTCP_MAP_SVH
`define RTCP_MAP_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define RTCP_OFS_CTRL 8'h00
`define RTCP_OFS_COUNT 8'h04
`define RTCP_OFS_COMPARE 8'h08
`define RTCP_OFS_STATUS 8'h0C
`define RTCP_OFS_INTCLR 8'h10
`define RTCP_OFS_INTEN 8'h14
`define RTCP_OFS_EVEN 8'h18
`define RTCP_OFS_WAKEEN 8'h1C
`define RTCP_OFS_SYNC 8'h20
`define RTCP_OFS_READ_SYNC_REQUEST 8'h24

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define RTCP_CTRL_EN 0
`define RTCP_CTRL_CLRMATCH 1
`define RTCP_CTRL_CONT_READ_SYNC 2
`define RTCP_CTRL_PSEL_LO 8
`define RTCP_FLAG_CMP 0
`define RTCP_FLAG_OVF 1
`define RTCP_FLAG_PER 2
`define RTCP_EVEN_CMP 10
`define RTCP_EVEN_OVF 11

// ----------------------------------------------------------------------
// Widths, reset values and timing counts
// ----------------------------------------------------------------------
`define RTCP_CNT_W 32
`define RTCP_PRESC_W 10
`define RTCP_PSEL_W 4
`define RTCP_FLAG_W 3
`define RTCP_SYNC_BUS_CYC 6
`define RTCP_CTRL_RST 32'h0000_0000
`define RTCP_COMPARE_RST 32'hFFFF_FFFF

`endif

// ===== core/rtcp_pkg.sv
// Types shared by the real-time counter modules.
package rtcp_pkg;

    // States of the counter-to-bus read synchroniser.
    typedef enum logic [1:0] {
        SYNC_IDLE,
        SYNC_CAPT,
        SYNC_XFER
    } rtcp_sync_st_t;

endpackage : rtcp_pkg

// ===== core/rtcp_tick_if.sv
// Signals between the counter core and its prescaler.
`timescale 1ns/1ps
interface rtcp_tick_if #(parameter int PRESC_W = 10, parameter int PSEL_W = 4);
    logic gen_clk;
    logic en;
    logic [PSEL_W-1:0] psel;
    logic edge_p;
    logic tick;
    logic [PRESC_W-1:0] tap;

    modport ctl (output gen_clk, output en, output psel,
                 input edge_p, input tick, input tap);
    modport presc (input gen_clk, input en, input psel,
                   output edge_p, output tick, output tap);
endinterface : rtcp_tick_if

// ===== core/rtcp_prescaler.sv
// Programmable power-of-two prescaler fed by the generic clock level.
`timescale 1ns/1ps
`include "rtcp_map.svh"
module rtcp_prescaler #(
    parameter int PRESC_W = `RTCP_PRESC_W,
    parameter int PSEL_W = `RTCP_PSEL_W
) (
    input wire logic i_clk,
    input wire logic i_rst_b,
    rtcp_tick_if.presc tk
);
    logic gen_clk_q;
    logic [PRESC_W-1:0] presc;

    // True when the lowest k bits of v are all ones.
    function automatic logic low_ones(input logic [PRESC_W-1:0] v,
                                      input int k);
        logic r;
        r = 1'b1;
        for (int i = 0; i < PRESC_W; i++) begin
            if (i < k && !v[i]) begin
                r = 1'b0;
            end
        end
        return r;
    endfunction : low_ones

    // The generic clock is sampled as a level; its rising edge paces the
    // counter side, so the bus clock must be well above it.
    assign tk.edge_p = tk.gen_clk && !gen_clk_q && tk.en;

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            gen_clk_q <= 1'b0;
        end else begin
            gen_clk_q <= tk.gen_clk;
        end
    end

    // The divider is held at zero while disabled so taps restart in phase.
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            presc <= '0;
        end else if (!tk.en) begin
            presc <= '0;
        end else if (tk.edge_p) begin
            presc <= presc + 1'b1;
        end
    end

    // Select values above the divider width saturate at the full ratio.
    always_comb begin
        int k;
        k = (int'(tk.psel) > PRESC_W) ? PRESC_W : int'(tk.psel);
        tk.tick = tk.edge_p && low_ones(presc, k);
    end

    // Stage n rises when the low n bits are ones and bit n is zero.
    always_comb begin
        for (int n = 0; n < PRESC_W; n++) begin
            tk.tap[n] = tk.edge_p && low_ones(presc, n) && !presc[n];
        end
    end
endmodule : rtcp_prescaler

// ===== test/rtcp_rtc_chk.sv
// Port-level assertions for the real-time counter.
`timescale 1ns/1ps
`include "rtcp_map.svh"
module rtcp_rtc_chk #(
    parameter int CNT_W = 32,
    parameter int PRESC_W = 10,
    parameter int SYNC_CYC = 6
) (
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic i_counter_generic_clock,
    input wire logic [7:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [31:0] o_rdata,
    input wire logic o_irq,
    input wire logic o_wake,
    input wire logic [PRESC_W-1:0] o_evt_periodic,
    input wire logic o_evt_compare,
    input wire logic o_evt_overflow
);
    // ----
    // Properties
    // ----
    // One clock domain, so clock and reset are given once.
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rst_b);

    AST_RST_OUT: assert property ($rose(i_rst_b) |-> !o_irq && !o_wake
        && o_rdata == 32'h0) else $error("outputs busy after reset");
    AST_RDATA_IDLE: assert property (!$past(i_rd) |-> o_rdata == 32'h0)
        else $error("read data outside the read slot");
    AST_EVT_CMP: assert property (o_evt_compare |=> !o_evt_compare)
        else $error("compare event longer than one cycle");
    AST_EVT_OVF: assert property (o_evt_overflow |=> !o_evt_overflow[*3])
        else $error("overflow event repeats too soon");
    AST_IRQ_MASK: assert property (i_wr && i_addr == `RTCP_OFS_INTEN
        && i_wdata[2:0] == 3'h0 |=> ##1 !o_irq) else $error("irq not masked");
    AST_WAKE_MASK: assert property (i_wr && i_addr == `RTCP_OFS_WAKEEN
        && i_wdata[2:0] == 3'h0 |=> ##1 !o_wake) else $error("wake not masked");
    // The output register may hold a pulse for one cycle, hence the delay.
    AST_EVT_GATE: assert property (i_wr && i_addr == `RTCP_OFS_EVEN
        && i_wdata[11:0] == 12'h0 |-> ##3 (o_evt_periodic == '0
        && !o_evt_compare && !o_evt_overflow)[*4])
        else $error("event pulse while all events disabled");
    AST_TAP_SPACING: assert property (o_evt_periodic[0]
        |=> !o_evt_periodic[0][*3]) else $error("first tap too fast");
    AST_TAP_EXCL: assert property (o_evt_periodic[1]
        |-> !o_evt_periodic[0]) else $error("tap zero and tap one together");

    // Main scenarios reached.
    cover property (o_evt_overflow);
    cover property (o_evt_compare);
    cover property ($rose(o_irq));
    cover property ($rose(o_wake));
endmodule : rtcp_rtc_chk

bind rtcp_rtc rtcp_rtc_chk #(.CNT_W(CNT_W), .PRESC_W(PRESC_W),
    .SYNC_CYC(SYNC_CYC)) u_chk (.i_clk(i_clk), .i_rst_b(i_rst_b),
    .i_counter_generic_clock(i_counter_generic_clock), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .o_irq(o_irq), .o_wake(o_wake), .o_evt_periodic(o_evt_periodic),
    .o_evt_compare(o_evt_compare), .o_evt_overflow(o_evt_overflow));

// ===== test/rtcp_generic_clock_unit_model.sv
// Generic clock source that feeds the counter in counted bursts.
`timescale 1ns/1ps
module rtcp_gen_clock_model (
    input wire logic i_clk,
    output logic o_gen_clk
);
    // Stands low between bursts so each run gives an exact edge count.
    initial begin
        o_gen_clk = 1'b0;
    end

    // Makes n rising edges, each level held for half bus cycles; levels
    // change just after a bus clock edge, so the sampling never races.
    task automatic burst(input int n, input int half);
        for (int i = 0; i < n; i++) begin
            repeat (half) @(posedge i_clk);
            o_gen_clk <= 1'b1;
            repeat (half) @(posedge i_clk);
            o_gen_clk <= 1'b0;
        end
    endtask : burst
endmodule : rtcp_gen_clock_model

// ===== test/rtcp_testbench.sv
// Self-checking bench for the real-time counter.
`timescale 1ns/1ps
`include "rtcp_map.svh"
module testbench;
    // ----
    // Signals
    // ----
    typedef struct {
        logic [31:0] exp;
        bit chk;
    } rtcp_note_t;
    logic i_clk;
    logic i_rst_b;
    logic gen_clk;
    logic [7:0] i_addr;
    logic [31:0] i_wdata;
    logic i_wr;
    logic i_rd;
    logic [31:0] o_rdata;
    logic o_irq;
    logic o_wake;
    logic [9:0] o_evt_periodic;
    logic o_evt_compare;
    logic o_evt_overflow;
    rtcp_note_t notes[$];
    rtcp_note_t nt;
    int num_errors = 0;
    int n_tests = 0;
    int n_cmp = 0;
    int n_ovf = 0;
    int n_tap0 = 0;
    int n_tap1 = 0;
    logic rd_d = 1'b0;
    logic [31:0] d;
    logic [31:0] v;

    rtcp_gen_clock_model gen (.i_clk(i_clk), .o_gen_clk(gen_clk));
    rtcp_rtc uut (.i_clk(i_clk), .i_rst_b(i_rst_b),
        .i_counter_generic_clock(gen_clk), .i_addr(i_addr),
        .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_irq(o_irq),
        .o_wake(o_wake), .o_evt_periodic(o_evt_periodic),
        .o_evt_compare(o_evt_compare), .o_evt_overflow(o_evt_overflow));

    // ----
    // Tasks
    // ----
    task automatic check(input string name, input logic [31:0] seen,
                         input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %s exp %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic wr(input logic [7:0] a, input logic [31:0] wd);
        @(posedge i_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= wd;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask : wr

    // The note is queued for the monitor; d keeps the word for polling.
    task automatic rd(input logic [7:0] a, input logic [31:0] e,
                      input bit c);
        @(posedge i_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        notes.push_back('{e, c});
        @(posedge i_clk);
        i_rd <= 1'b0;
        @(posedge i_clk);
        d = o_rdata;
    endtask : rd

    // Polls a sync status bit until it drops, at most lim reads.
    task automatic sync_wait(input int b, input int lim);
        int k;
        k = 0;
        do begin
            rd(`RTCP_OFS_SYNC, 32'h0, 1'b0);
            k++;
        end while (d[b] !== 1'b0 && k < lim);
        check("sync_done", {31'h0, d[b]}, 32'h0);
    endtask : sync_wait

    // Runs counter edges, stops the counter and fetches its value.
    task automatic run(input int n, input int half);
        gen.burst(n, half);
        repeat (6) @(posedge i_clk);
        wr(`RTCP_OFS_CTRL, 32'h0);
        wr(`RTCP_OFS_READ_SYNC_REQUEST, 32'h1);
        sync_wait(0, 20);
    endtask : run

    task automatic results;
        if (num_errors == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : results

    // ----
    // Clock, monitor and watchdog
    // ----
    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end

    // Read data is compared with the oldest note one cycle after a read.
    always @(posedge i_clk) begin
        if (rd_d && notes.size() > 0) begin
            nt = notes.pop_front();
            if (nt.chk) check("rdata", o_rdata, nt.exp);
        end
        rd_d <= i_rd;
        if (o_evt_compare === 1'b1) n_cmp++;
        if (o_evt_overflow === 1'b1) n_ovf++;
        if (o_evt_periodic[0] === 1'b1) n_tap0++;
        if (o_evt_periodic[1] === 1'b1) n_tap1++;
    end

    // The sequence needs well under a thousand cycles; this only cuts a hang.
    initial begin
        #500000;
        num_errors++;
        results();
    end

    // ----
    // Main sequence
    // ----
    initial begin
        i_rst_b = 1'b0;
        i_addr = 8'h00;
        i_wdata = 32'h0;
        i_wr = 1'b0;
        i_rd = 1'b0;
        void'($urandom(32'hDC364EBB));
        repeat (12) @(posedge i_clk);
        i_rst_b <= 1'b1;
        // Reset values, a read-only place and an unmapped place.
        rd(`RTCP_OFS_CTRL, 32'h0, 1'b1);
        rd(`RTCP_OFS_COMPARE, 32'hFFFFFFFF, 1'b1);
        wr(`RTCP_OFS_STATUS, 32'hFFFFFFFF);
        rd(`RTCP_OFS_STATUS, 32'h0, 1'b1);
        rd(8'h40, 32'h0, 1'b1);
        v = $urandom;
        wr(`RTCP_OFS_COUNT, v);
        rd(`RTCP_OFS_COUNT, v, 1'b1);
        wr(`RTCP_OFS_COMPARE, ~v);
        rd(`RTCP_OFS_COMPARE, ~v, 1'b1);
        wr(`RTCP_OFS_EVEN, 32'hFFFFFFFF);
        rd(`RTCP_OFS_EVEN, 32'h00000FFF, 1'b1);
        // Wrap past the top, then match a small compare value.
        wr(`RTCP_OFS_EVEN, 32'h00000C00);
        wr(`RTCP_OFS_INTEN, 32'h3);
        wr(`RTCP_OFS_WAKEEN, 32'h2);
        wr(`RTCP_OFS_COUNT, 32'hFFFFFFFD);
        wr(`RTCP_OFS_COMPARE, 32'h5);
        wr(`RTCP_OFS_CTRL, 32'h1);
        run(10, 3);
        rd(`RTCP_OFS_COUNT, 32'h7, 1'b1);
        rd(`RTCP_OFS_STATUS, 32'h3, 1'b1);
        check("evt_ovf", n_ovf, 32'h1);
        check("evt_cmp", n_cmp, 32'h1);
        check("irq", o_irq, 32'h1);
        check("wake", o_wake, 32'h1);
        wr(`RTCP_OFS_INTEN, 32'h0);
        repeat (2) @(posedge i_clk);
        check("irq_mask", o_irq, 32'h0);
        wr(`RTCP_OFS_INTCLR, 32'h1);
        rd(`RTCP_OFS_STATUS, 32'h2, 1'b1);
        wr(`RTCP_OFS_INTCLR, 32'h2);
        rd(`RTCP_OFS_STATUS, 32'h0, 1'b1);
        check("wake_clr", o_wake, 32'h0);
        // Divide by four with two taps producing events.
        wr(`RTCP_OFS_EVEN, 32'h3);
        wr(`RTCP_OFS_WAKEEN, 32'h4);
        wr(`RTCP_OFS_COUNT, 32'h0);
        wr(`RTCP_OFS_CTRL, 32'h00000201);
        run(16, 7);
        rd(`RTCP_OFS_COUNT, 32'h4, 1'b1);
        rd(`RTCP_OFS_STATUS, 32'h4, 1'b1);
        check("tap0", n_tap0, 32'h8);
        check("tap1", n_tap1, 32'h4);
        check("wake_per", o_wake, 32'h1);
        wr(`RTCP_OFS_INTCLR, 32'h7);
        // Clear on match gives a compare every fourth tick.
        n_cmp = 0;
        n_ovf = 0;
        wr(`RTCP_OFS_EVEN, 32'h00000C00);
        wr(`RTCP_OFS_COMPARE, 32'h3);
        wr(`RTCP_OFS_COUNT, 32'h0);
        wr(`RTCP_OFS_CTRL, 32'h3);
        run(16, 3);
        rd(`RTCP_OFS_COUNT, 32'h0, 1'b1);
        check("cmp_period", n_cmp, 32'h4);
        check("no_ovf", n_ovf, 32'h0);
        // Continuous sync holds a count write until the copy completes.
        v = $urandom;
        wr(`RTCP_OFS_CTRL, 32'h4);
        rd(`RTCP_OFS_SYNC, 32'h0, 1'b0);
        check("sync_busy", {31'h0, d[0]}, 32'h1);
        wr(`RTCP_OFS_COUNT, v);
        sync_wait(1, 5);
        rd(`RTCP_OFS_COUNT, v, 1'b1);
        wr(`RTCP_OFS_CTRL, 32'h5);
        wr(`RTCP_OFS_EVEN, 32'h0);
        gen.burst(5, 3);
        repeat (6) @(posedge i_clk);
        wr(`RTCP_OFS_CTRL, 32'h4);
        repeat (20) @(posedge i_clk);
        rd(`RTCP_OFS_COUNT, v + 32'h5, 1'b1);
        repeat (2) @(posedge i_clk);
        results();
    end
endmodule : testbench
